/* fasr_defines.vh */
`ifndef FASR_DEFINES_VH
`define FASR_DEFINES_VH

`define FASR_ADDR_W 8
`define FASR_DATA_W 16
`define FASR_FAULT_STATUS_ONE_ADDR 8'h05
`define FASR_FAULT_STATUS_ONE_RST 16'h0000

`define FASR_BIT_OSC_PRI 15
`define FASR_BIT_OSC_RED 14
`define FASR_BIT_UP_SE_PRI 13
`define FASR_BIT_LO_SE_PRI 12
`define FASR_BIT_UP_SE_RED 11
`define FASR_BIT_LO_SE_RED 10
`define FASR_BIT_RAIL_HI 9
`define FASR_BIT_RAIL_LO 7
`define FASR_BIT_GND_HI 6
`define FASR_BIT_GND_LO 4
`define FASR_BIT_HV_UV 3
`define FASR_BIT_HV_HDRM 2
`define FASR_BIT_HV_OV 1
`define FASR_BIT_BAL_SUM 0

`define FASR_BAL_SW_N 14
`define FASR_CLK_PERIOD_NS 10
`define FASR_LFO_PERIOD_NS 30518
`define FASR_LFO_CYCLES_PER_CHECK 2
`define FASR_OSC_TOL_PCT 5
`define FASR_OSC_NOM_CYCLES (`FASR_LFO_CYCLES_PER_CHECK * `FASR_LFO_PERIOD_NS / `FASR_CLK_PERIOD_NS)

`endif

/* fasr_osc_check.v */
`timescale 1ns/1ps
`include "fasr_defines.vh"
// measures two slow oscillator periods in fast clock cycles
module fasr_osc_check #(
   parameter NOM_CYCLES = `FASR_OSC_NOM_CYCLES,
   parameter TOL_PCT = `FASR_OSC_TOL_PCT,
   parameter CNT_W = 16
)(
   input wire clock_in,
   input wire srst_in,
   input wire low_freq_oscillator_in,
   output reg fault_out,
   output reg update_out
);
   localparam integer TOL_CYC = NOM_CYCLES * TOL_PCT / 100;
   localparam integer LO_LIM = NOM_CYCLES - TOL_CYC;
   localparam integer HI_LIM = NOM_CYCLES + TOL_CYC;
   localparam integer OVER_INT = HI_LIM + 1;
   localparam [CNT_W-1:0] OVER_CNT = OVER_INT[CNT_W-1:0];

   reg lfo_d_r;
   reg armed_r;
   reg half_r;
   reg [CNT_W-1:0] cnt_r;
   wire rise;

   function off_window;
      input [CNT_W-1:0] cnt;
      begin
         off_window = (cnt < LO_LIM) || (cnt > HI_LIM);
      end
   endfunction

   assign rise = low_freq_oscillator_in & ~lfo_d_r;

   // result refreshed every second rising slow edge; a stalled oscillator times out
   always @(posedge clock_in)
   begin
      if (srst_in)
      begin
         lfo_d_r <= 1'b1;
         armed_r <= 1'b0;
         half_r <= 1'b0;
         cnt_r <= {CNT_W{1'b0}};
         fault_out <= 1'b0;
         update_out <= 1'b0;
      end
      else
      begin
         lfo_d_r <= low_freq_oscillator_in;
         update_out <= 1'b0;
         if (rise && !armed_r)
         begin
            armed_r <= 1'b1;
            half_r <= 1'b0;
            cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
         end
         else if (rise && half_r)
         begin
            fault_out <= off_window(cnt_r);
            update_out <= 1'b1;
            half_r <= 1'b0;
            cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
         end
         else if (rise)
         begin
            half_r <= 1'b1;
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         else if (armed_r && cnt_r == OVER_CNT)
         begin
            fault_out <= 1'b1;
            update_out <= 1'b1;
            armed_r <= 1'b0;
         end
         else if (armed_r)
         begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* fasr_top.v */
`timescale 1ns/1ps
`include "fasr_defines.vh"
// fault alert status register with its fault latches
module fasr_top #(
   parameter ADDR_W = `FASR_ADDR_W,
   parameter OSC_NOM_CYCLES = `FASR_OSC_NOM_CYCLES,
   parameter OSC_TOL_PCT = `FASR_OSC_TOL_PCT
)(
   input wire clock_in,
   input wire srst_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire [15:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [15:0] rdata_out,
   input wire low_freq_oscillator_in,
   input wire reset_alert_flag_in,
   input wire upper_port_single_ended_in,
   input wire lower_port_single_ended_in,
   input wire [2:0] supply_rail_fault_in,
   input wire [2:0] ground_open_fault_in,
   input wire high_supply_undervoltage_in,
   input wire high_supply_headroom_in,
   input wire measure_active_in,
   input wire high_supply_overvoltage_in,
   input wire [13:0] balance_switch_fault_bits_in,
   input wire balance_switch_diag_scan_done_in,
   output reg [15:0] fault_alert_status_one_out,
   output reg osc_check_update_out
);
   // stored bits
   reg slow_osc_fault_primary_r;
   reg slow_osc_fault_redundant_r;
   reg upper_port_single_ended_primary_r;
   reg lower_port_single_ended_primary_r;
   reg upper_port_single_ended_redundant_r;
   reg lower_port_single_ended_redundant_r;
   reg [2:0] supply_rail_fault_r;
   reg [2:0] ground_open_fault_r;
   reg high_supply_undervoltage_fault_r;
   reg high_supply_headroom_fault_r;
   reg high_supply_overvoltage_fault_r;
   reg balance_switch_fault_summary_r;

   reg slow_osc_fault_primary_nxt;
   reg slow_osc_fault_redundant_nxt;
   reg [2:0] supply_rail_fault_nxt;
   reg [2:0] ground_open_fault_nxt;
   reg high_supply_undervoltage_fault_nxt;
   reg high_supply_headroom_fault_nxt;
   reg high_supply_overvoltage_fault_nxt;
   reg balance_switch_fault_summary_nxt;

   wire osc_fault_pri;
   wire osc_fault_red;
   wire osc_upd_pri;
   wire osc_upd_red;
   wire reg_hit;
   wire reg_wr;
   wire gate_open;
   wire [15:0] clr_req;
   reg [15:0] status_now;
   wire bal_any;

   // w0c next value: set wins over a clear in the same cycle
   function w0c_next;
      input cur;
      input set;
      input clr;
      input still_bad;
      begin
         if (set)
            w0c_next = 1'b1;
         else if (clr && !still_bad)
            w0c_next = 1'b0;
         else
            w0c_next = cur;
      end
   endfunction

   // register select
   function is_fault_status_one;
      input [ADDR_W-1:0] addr;
      begin
         is_fault_status_one = (addr == `FASR_FAULT_STATUS_ONE_ADDR);
      end
   endfunction

   // two independent checkers feed the primary and redundant latches
   fasr_osc_check #(
      .NOM_CYCLES(OSC_NOM_CYCLES),
      .TOL_PCT(OSC_TOL_PCT),
      .CNT_W(16)
   ) u_osc_pri (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .low_freq_oscillator_in(low_freq_oscillator_in),
      .fault_out(osc_fault_pri),
      .update_out(osc_upd_pri)
   );

   fasr_osc_check #(
      .NOM_CYCLES(OSC_NOM_CYCLES),
      .TOL_PCT(OSC_TOL_PCT),
      .CNT_W(16)
   ) u_osc_red (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .low_freq_oscillator_in(low_freq_oscillator_in),
      .fault_out(osc_fault_red),
      .update_out(osc_upd_red)
   );

   // address decode and write-zero clear requests
   assign reg_hit = is_fault_status_one(addr_in);
   assign reg_wr = wr_in && reg_hit;
   assign clr_req = {16{reg_wr}} & ~wdata_in;
   assign gate_open = ~reset_alert_flag_in;
   assign bal_any = |balance_switch_fault_bits_in;

   // register image assembled from the bit map
   always @*
   begin
      status_now = `FASR_FAULT_STATUS_ONE_RST;
      status_now[`FASR_BIT_OSC_PRI] = slow_osc_fault_primary_r;
      status_now[`FASR_BIT_OSC_RED] = slow_osc_fault_redundant_r;
      status_now[`FASR_BIT_UP_SE_PRI] = upper_port_single_ended_primary_r;
      status_now[`FASR_BIT_LO_SE_PRI] = lower_port_single_ended_primary_r;
      status_now[`FASR_BIT_UP_SE_RED] = upper_port_single_ended_redundant_r;
      status_now[`FASR_BIT_LO_SE_RED] = lower_port_single_ended_redundant_r;
      status_now[`FASR_BIT_RAIL_HI:`FASR_BIT_RAIL_LO] = supply_rail_fault_r;
      status_now[`FASR_BIT_GND_HI:`FASR_BIT_GND_LO] = ground_open_fault_r;
      status_now[`FASR_BIT_HV_UV] = high_supply_undervoltage_fault_r;
      status_now[`FASR_BIT_HV_HDRM] = high_supply_headroom_fault_r;
      status_now[`FASR_BIT_HV_OV] = high_supply_overvoltage_fault_r;
      status_now[`FASR_BIT_BAL_SUM] = balance_switch_fault_summary_r;
   end

   // oscillator fault latches
   always @*
   begin
      slow_osc_fault_primary_nxt = w0c_next(
         slow_osc_fault_primary_r,
         osc_fault_pri,
         clr_req[`FASR_BIT_OSC_PRI],
         osc_fault_pri);
      slow_osc_fault_redundant_nxt = w0c_next(
         slow_osc_fault_redundant_r,
         osc_fault_red,
         clr_req[`FASR_BIT_OSC_RED],
         osc_fault_red);
   end

   // supply rail and ground latches, gated by the reset alert
   always @*
   begin
      supply_rail_fault_nxt[2] = w0c_next(
         supply_rail_fault_r[2],
         supply_rail_fault_in[2] & gate_open,
         clr_req[`FASR_BIT_RAIL_HI],
         supply_rail_fault_in[2]);
      supply_rail_fault_nxt[1] = w0c_next(
         supply_rail_fault_r[1],
         supply_rail_fault_in[1] & gate_open,
         clr_req[`FASR_BIT_RAIL_LO + 1],
         supply_rail_fault_in[1]);
      supply_rail_fault_nxt[0] = w0c_next(
         supply_rail_fault_r[0],
         supply_rail_fault_in[0] & gate_open,
         clr_req[`FASR_BIT_RAIL_LO],
         supply_rail_fault_in[0]);
      ground_open_fault_nxt[2] = w0c_next(
         ground_open_fault_r[2],
         ground_open_fault_in[2] & gate_open,
         clr_req[`FASR_BIT_GND_HI],
         1'b0);
      ground_open_fault_nxt[1] = w0c_next(
         ground_open_fault_r[1],
         ground_open_fault_in[1] & gate_open,
         clr_req[`FASR_BIT_GND_LO + 1],
         1'b0);
      ground_open_fault_nxt[0] = w0c_next(
         ground_open_fault_r[0],
         ground_open_fault_in[0] & gate_open,
         clr_req[`FASR_BIT_GND_LO],
         1'b0);
   end

   // high supply latches
   always @*
   begin
      high_supply_undervoltage_fault_nxt = w0c_next(
         high_supply_undervoltage_fault_r,
         high_supply_undervoltage_in & gate_open,
         clr_req[`FASR_BIT_HV_UV],
         1'b0);
      high_supply_headroom_fault_nxt = w0c_next(
         high_supply_headroom_fault_r,
         high_supply_headroom_in & measure_active_in,
         clr_req[`FASR_BIT_HV_HDRM],
         1'b0);
      high_supply_overvoltage_fault_nxt = w0c_next(
         high_supply_overvoltage_fault_r,
         high_supply_overvoltage_in & gate_open,
         clr_req[`FASR_BIT_HV_OV],
         1'b0);
   end

   // balance switch summary: refreshed at scan end, auto clear when resolved
   always @*
   begin
      if (balance_switch_diag_scan_done_in)
         balance_switch_fault_summary_nxt = bal_any;
      else if (!bal_any)
         balance_switch_fault_summary_nxt = 1'b0;
      else if (clr_req[`FASR_BIT_BAL_SUM])
         balance_switch_fault_summary_nxt = 1'b0;
      else
         balance_switch_fault_summary_nxt = balance_switch_fault_summary_r;
   end

   // state registers
   always @(posedge clock_in)
   begin
      if (srst_in)
      begin
         slow_osc_fault_primary_r <= 1'b0;
         slow_osc_fault_redundant_r <= 1'b0;
         supply_rail_fault_r <= 3'h0;
         ground_open_fault_r <= 3'h0;
         high_supply_undervoltage_fault_r <= 1'b0;
         high_supply_headroom_fault_r <= 1'b0;
         high_supply_overvoltage_fault_r <= 1'b0;
         balance_switch_fault_summary_r <= 1'b0;
      end
      else
      begin
         slow_osc_fault_primary_r <= slow_osc_fault_primary_nxt;
         slow_osc_fault_redundant_r <= slow_osc_fault_redundant_nxt;
         supply_rail_fault_r <= supply_rail_fault_nxt;
         ground_open_fault_r <= ground_open_fault_nxt;
         high_supply_undervoltage_fault_r <=
            high_supply_undervoltage_fault_nxt;
         high_supply_headroom_fault_r <= high_supply_headroom_fault_nxt;
         high_supply_overvoltage_fault_r <=
            high_supply_overvoltage_fault_nxt;
         balance_switch_fault_summary_r <= balance_switch_fault_summary_nxt;
      end
   end

   // primary single-ended flags: detection only, held off by reset alert
   always @(posedge clock_in)
   begin
      if (srst_in)
      begin
         upper_port_single_ended_primary_r <= 1'b0;
         lower_port_single_ended_primary_r <= 1'b0;
      end
      else
      begin
         if (upper_port_single_ended_in && gate_open)
            upper_port_single_ended_primary_r <= 1'b1;
         if (lower_port_single_ended_in && gate_open)
            lower_port_single_ended_primary_r <= 1'b1;
      end
   end

   // redundant single-ended flags: detection only, never gated
   always @(posedge clock_in)
   begin
      if (srst_in)
      begin
         upper_port_single_ended_redundant_r <= 1'b0;
         lower_port_single_ended_redundant_r <= 1'b0;
      end
      else
      begin
         if (upper_port_single_ended_in)
            upper_port_single_ended_redundant_r <= 1'b1;
         if (lower_port_single_ended_in)
            lower_port_single_ended_redundant_r <= 1'b1;
      end
   end

   // read port, status mirror and check pulse
   always @(posedge clock_in)
   begin
      if (srst_in)
      begin
         rdata_out <= `FASR_FAULT_STATUS_ONE_RST;
         fault_alert_status_one_out <= `FASR_FAULT_STATUS_ONE_RST;
         osc_check_update_out <= 1'b0;
      end
      else
      begin
         fault_alert_status_one_out <= status_now;
         osc_check_update_out <= osc_upd_pri | osc_upd_red;
         if (rd_in && reg_hit)
            rdata_out <= status_now;
         else
            rdata_out <= 16'h0000;
      end
   end
endmodule

/* fasr_top_asserts.sv */
`timescale 1ns/1ps
module fasr_top_asserts #(
   parameter ADDR_W = 8
)(
   input wire clock_in,
   input wire srst_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire [15:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [15:0] rdata_out,
   input wire reset_alert_flag_in,
   input wire upper_port_single_ended_in,
   input wire lower_port_single_ended_in,
   input wire high_supply_headroom_in,
   input wire measure_active_in,
   input wire [2:0] supply_rail_fault_in,
   input wire [2:0] ground_open_fault_in,
   input wire [13:0] balance_switch_fault_bits_in,
   input wire balance_switch_diag_scan_done_in,
   input wire [15:0] fault_alert_status_one_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (srst_in);
   wire [15:0] st;
   assign st = fault_alert_status_one_out;
   sequence s_wr_reg;
      wr_in && addr_in == 8'h05;
   endsequence
   a_ground_set: assert property (
      (ground_open_fault_in[0] && !reset_alert_flag_in) |-> ##2 st[4])
      else $error("ground bit not set");
   a_rail_gate: assert property (
      $rose(st[9]) |->
      $past(supply_rail_fault_in[2] && !reset_alert_flag_in, 2))
      else $error("rail bit set while gated");
   a_upper_copy: assert property (
      upper_port_single_ended_in |-> ##2 st[11])
      else $error("redundant port flag missing");
   a_upper_primary: assert property (
      (upper_port_single_ended_in && !reset_alert_flag_in) |-> ##2 st[13])
      else $error("primary port flag missing");
   a_lower_primary: assert property (
      (lower_port_single_ended_in && !reset_alert_flag_in) |-> ##2 st[12])
      else $error("lower primary port flag missing");
   a_ro_sticky: assert property (
      !$past(srst_in) |->
      ((st[13:10] & $past(st[13:10])) == $past(st[13:10])))
      else $error("read-only flag cleared");
   a_clear_zero: assert property (
      s_wr_reg ##0 (!wdata_in[4] && !ground_open_fault_in[0])
      |-> ##2 !st[4])
      else $error("ground bit not cleared");
   a_write_ones: assert property (
      s_wr_reg ##0 (wdata_in == 16'hFFFF) |-> ##2
      (((st & $past(st)) | 16'h0001) == ($past(st) | 16'h0001)))
      else $error("write of ones changed bits");
   a_rail_hold: assert property (
      s_wr_reg ##0 (!wdata_in[9] && supply_rail_fault_in[2]) ##1 st[9]
      |-> ##1 st[9])
      else $error("rail bit cleared while still bad");
   a_hdrm_gate: assert property (
      $rose(st[2]) |->
      $past(high_supply_headroom_in && measure_active_in, 2))
      else $error("headroom bit set outside measurement");
   a_osc_pair: assert property (
      st[15] == st[14])
      else $error("oscillator copies differ");
   a_bal_scan: assert property (
      (balance_switch_diag_scan_done_in && |balance_switch_fault_bits_in)
      |-> ##2 st[0])
      else $error("summary not set");
   a_bal_auto: assert property (
      (balance_switch_fault_bits_in == 14'h0000) |-> ##2 !st[0])
      else $error("summary not auto cleared");
   a_osc_w0c: assert property (
      (!$past(srst_in) && $fell(st[15])) |->
      $past(wr_in && addr_in == 8'h05 && !wdata_in[15], 2))
      else $error("osc bit fell without write");
   a_rd_quiet: assert property (
      (!rd_in || addr_in != 8'h05) |=> rdata_out == 16'h0000)
      else $error("read data not zero");
endmodule
bind fasr_top fasr_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.clock_in,
   .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
   .reset_alert_flag_in, .upper_port_single_ended_in,
   .lower_port_single_ended_in, .high_supply_headroom_in,
   .measure_active_in, .supply_rail_fault_in, .ground_open_fault_in,
   .balance_switch_fault_bits_in, .balance_switch_diag_scan_done_in,
   .fault_alert_status_one_out);

/* fault_alert_status_register_tb.sv */
`timescale 1ns/1ps
module fault_alert_status_register_tb;
   reg clock_in = 0;
   reg srst_in = 1;
   reg [7:0] addr_in = 8'h00;
   reg [15:0] wdata_in = 16'h0000;
   reg wr_in = 0, rd_in = 0, lfo = 0, alert = 0, up_se = 0, lo_se = 0;
   reg [2:0] rail = 0, gnd = 0;
   reg uv = 0, hdrm = 0, meas = 0, ov = 0, scan = 0, rd_d = 0;
   reg [13:0] bal = 0;
   wire [15:0] rdata;
   wire upd;
   wire [15:0] stat;
   logic [15:0] e;
   logic [15:0] exp_q[$];
   int half_p = 25;
   int n_fail = 0;
   int check_count = 0;
   fasr_top #(.OSC_NOM_CYCLES(100)) dut (.clock_in(clock_in),
      .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
      .low_freq_oscillator_in(lfo), .reset_alert_flag_in(alert),
      .upper_port_single_ended_in(up_se),
      .lower_port_single_ended_in(lo_se), .supply_rail_fault_in(rail),
      .ground_open_fault_in(gnd), .high_supply_undervoltage_in(uv),
      .high_supply_headroom_in(hdrm), .measure_active_in(meas),
      .high_supply_overvoltage_in(ov),
      .balance_switch_fault_bits_in(bal),
      .balance_switch_diag_scan_done_in(scan),
      .fault_alert_status_one_out(stat), .osc_check_update_out(upd));
   always #5 clock_in = ~clock_in;
   // slow oscillator, period 2 * half_p clocks
   always
   begin
      repeat (half_p) @(posedge clock_in);
      lfo <= ~lfo;
   end
   // read data compared against oldest expectation
   always @(posedge clock_in)
   begin
      if (rd_d)
      begin
         e = exp_q.pop_front();
         check_count++;
         if (rdata !== e)
         begin
            n_fail++;
            $display("[FAIL] %0t read %h expected %h", $time, rdata, e);
         end
         check_count++;
         if (stat !== e)
         begin
            n_fail++;
            $display("[FAIL] %0t status %h expected %h", $time, stat, e);
         end
      end
      rd_d <= rd_in;
   end
   task results();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task wr(input [7:0] a, input [15:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1;
      @(posedge clock_in);
      wr_in <= 0;
      repeat (2) @(posedge clock_in);
   endtask
   task rd(input [7:0] a, input [15:0] d);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1;
      exp_q.push_back(d);
      @(posedge clock_in);
      rd_in <= 0;
      @(posedge clock_in);
   endtask
   // one cycle of fault pattern v, then pattern k
   task flt(input [9:0] v, input [9:0] k);
      @(posedge clock_in);
      {up_se, lo_se, rail, gnd, uv, ov} <= v;
      @(posedge clock_in);
      {up_se, lo_se, rail, gnd, uv, ov} <= k;
      @(posedge clock_in);
   endtask
   task scan_p();
      @(posedge clock_in);
      scan <= 1;
      @(posedge clock_in);
      scan <= 0;
   endtask
   task wait_upd(input int n);
      int t;
      t = 0;
      while (n > 0)
      begin
         @(posedge clock_in);
         t++;
         if (upd)
            n--;
         if (t > 3000)
         begin
            n_fail++;
            results();
         end
      end
   endtask
   initial
   begin
      void'($urandom(32'hf9a8));
      repeat (3) @(posedge clock_in);
      srst_in <= 0;
      rd(8'h05, 16'h0000);
      rd(8'h06, 16'h0000);
      hdrm <= 1;
      alert <= 1;
      flt(10'h3FF, 10'h000);
      alert <= 0;
      rd(8'h05, 16'h0C00);
      flt(10'h3FF, 10'h0E0);
      rd(8'h05, 16'h3FFA);
      wr(8'h05, 16'hFFFF);
      rd(8'h05, 16'h3FFA);
      wr(8'h06, 16'h0000);
      rd(8'h05, 16'h3FFA);
      wr(8'h05, 16'h0000);
      rd(8'h05, 16'h3F80);
      flt(10'h000, 10'h000);
      wr(8'h05, 16'hFC7F);
      rd(8'h05, 16'h3C00);
      @(posedge clock_in);
      meas <= 1;
      @(posedge clock_in);
      meas <= 0;
      hdrm <= 0;
      rd(8'h05, 16'h3C04);
      wr(8'h05, 16'h0000);
      rd(8'h05, 16'h3C00);
      bal <= 14'($urandom_range(16383, 1));
      rd(8'h05, 16'h3C00);
      scan_p();
      rd(8'h05, 16'h3C01);
      wr(8'h05, 16'h0000);
      rd(8'h05, 16'h3C00);
      scan_p();
      rd(8'h05, 16'h3C01);
      bal <= 14'h0000;
      rd(8'h05, 16'h3C00);
      half_p = 30;
      wait_upd(4);
      rd(8'h05, 16'hFC00);
      wr(8'h05, 16'h0000);
      rd(8'h05, 16'hFC00);
      half_p = 25;
      wait_upd(4);
      wr(8'h05, 16'h0000);
      rd(8'h05, 16'h3C00);
      srst_in <= 1;
      @(posedge clock_in);
      srst_in <= 0;
      rd(8'h05, 16'h0000);
      results();
   end
endmodule
